// ==== logic/rab_bank.v ====
// register bank with per-bit access attributes and two address regions
// assumes: one clock, register port strobes and hardware sources come from
// logic on clk, so no synchronisers are needed
`timescale 1ns/1ps
`include "rab_map.vh"

module rab_bank #(
    parameter [15:0]  CHIP_ID   = 16'h0A5A,   // arbitrary value
    parameter [15:0]  CHIP_REV  = 16'h0001,   // arbitrary value
    parameter [127:0] STAT_ATTR = `RAB_STAT_ATTR,
    parameter [127:0] CTRL_ATTR = `RAB_CTRL_ATTR,
    parameter [127:0] MAC_ATTR  = `RAB_MAC_ATTR,
    parameter [31:0]  STAT_RST  = `RAB_STAT_RST,
    parameter [31:0]  CTRL_RST  = `RAB_CTRL_RST,
    parameter [31:0]  MAC_RST   = `RAB_MAC_RST,
    parameter [31:0]  STAT_KEEP = `RAB_STAT_KEEP,
    parameter [31:0]  CTRL_KEEP = `RAB_CTRL_KEEP,
    parameter [31:0]  MAC_KEEP  = `RAB_MAC_KEEP
) (
    // clock and resets
    input  wire        clk,
    input  wire        rst_n,
    input  wire        soft_rst,
    // register access port
    input  wire        reg_rd,
    input  wire        reg_wr,
    input  wire [8:0]  reg_addr,
    input  wire [31:0] reg_wdata,
    output reg  [31:0] reg_rdata_reg,
    output reg         reg_rvalid_reg,
    // hardware sources and stored values
    input  wire [31:0] stat_src,
    output wire [31:0] stat_q,
    input  wire [31:0] ctrl_src,
    output wire [31:0] ctrl_q,
    input  wire [31:0] mac_src,
    output wire [31:0] mac_q,
    // region of the last access
    output reg         sys_hit_reg,
    output reg         mac_hit_reg
);

    // ----------------------------------------
    // region codes
    // ----------------------------------------
    localparam [1:0] RGN_NONE = 2'h0;
    localparam [1:0] RGN_SYS  = 2'h1;
    localparam [1:0] RGN_MAC  = 2'h2;

    // ----------------------------------------
    // address decode functions
    // ----------------------------------------
    // region code: 1 system, 2 mac, 0 outside any region
    function [1:0] rab_region;
        input [8:0] a;
        begin
            if (a[1:0] != 2'b00)
                rab_region = RGN_NONE;
            else if (a <= `RAB_SYS_HI)
                rab_region = RGN_SYS;
            else if ((a >= `RAB_MAC_LO) && (a <= `RAB_MAC_HI))
                rab_region = RGN_MAC;
            else
                rab_region = RGN_NONE;
        end
    endfunction

    // exact word hit on one register offset
    function rab_hit;
        input [8:0] a;
        input [8:0] ofs;
        begin
            rab_hit = (rab_region(a) != RGN_NONE) && (a == ofs);
        end
    endfunction

    // ----------------------------------------
    // per-register strobes
    // ----------------------------------------
    // region of the current access, held in the flags below
    wire [1:0] acc_region = rab_region(reg_addr);

    // word hits on the implemented offsets
    wire id_hit   = rab_hit(reg_addr, `RAB_ID_OFS);
    wire stat_hit = rab_hit(reg_addr, `RAB_STAT_OFS);
    wire ctrl_hit = rab_hit(reg_addr, `RAB_CTRL_OFS);
    wire mac_hit  = rab_hit(reg_addr, `RAB_MAC_OFS);

    // unmapped offsets produce no strobe, so writes there change only the region flags
    wire stat_rd = reg_rd && stat_hit;
    wire stat_wr = reg_wr && stat_hit;
    wire ctrl_rd = reg_rd && ctrl_hit;
    wire ctrl_wr = reg_wr && ctrl_hit;
    wire mac_rd  = reg_rd && mac_hit;
    wire mac_wr  = reg_wr && mac_hit;

    wire [31:0] stat_rv;
    wire [31:0] ctrl_rv;
    wire [31:0] mac_rv;

    // ----------------------------------------
    // bit cells
    // ----------------------------------------
    genvar i;
    generate
        for (i = 0; i < 32; i = i + 1) begin : g_bit
            // status register, mixed attributes
            rab_attr_bit #(
                .ATTR    (STAT_ATTR[4*i +: 4]),
                .KEEP    (STAT_KEEP[i]),
                .RST_VAL (STAT_RST[i])
            ) u_stat (
                .clk      (clk),
                .rst_n    (rst_n),
                .soft_rst (soft_rst),
                .rd       (stat_rd),
                .wr       (stat_wr),
                .wdat     (reg_wdata[i]),
                .src      (stat_src[i]),
                .q_reg    (stat_q[i]),
                .rd_val   (stat_rv[i])
            );
            // control register, upper half kept on soft reset
            rab_attr_bit #(
                .ATTR    (CTRL_ATTR[4*i +: 4]),
                .KEEP    (CTRL_KEEP[i]),
                .RST_VAL (CTRL_RST[i])
            ) u_ctrl (
                .clk      (clk),
                .rst_n    (rst_n),
                .soft_rst (soft_rst),
                .rd       (ctrl_rd),
                .wr       (ctrl_wr),
                .wdat     (reg_wdata[i]),
                .src      (ctrl_src[i]),
                .q_reg    (ctrl_q[i]),
                .rd_val   (ctrl_rv[i])
            );
            // mac region register
            rab_attr_bit #(
                .ATTR    (MAC_ATTR[4*i +: 4]),
                .KEEP    (MAC_KEEP[i]),
                .RST_VAL (MAC_RST[i])
            ) u_mac (
                .clk      (clk),
                .rst_n    (rst_n),
                .soft_rst (soft_rst),
                .rd       (mac_rd),
                .wr       (mac_wr),
                .wdat     (reg_wdata[i]),
                .src      (mac_src[i]),
                .q_reg    (mac_q[i]),
                .rd_val   (mac_rv[i])
            );
        end
    endgenerate

    // ----------------------------------------
    // read data select
    // ----------------------------------------
    // values are taken before any read side effect lands
    localparam [2:0] SEL_NONE = 3'h0;
    localparam [2:0] SEL_ID   = 3'h1;
    localparam [2:0] SEL_STAT = 3'h2;
    localparam [2:0] SEL_CTRL = 3'h3;
    localparam [2:0] SEL_MAC  = 3'h4;

    reg [2:0]  rd_sel;
    reg [31:0] rdata_next;

    // which register the access lands on; offsets make the hits exclusive
    always @* begin
        rd_sel = SEL_NONE;
        if (id_hit)
            rd_sel = SEL_ID;
        else if (stat_hit)
            rd_sel = SEL_STAT;
        else if (ctrl_hit)
            rd_sel = SEL_CTRL;
        else if (mac_hit)
            rd_sel = SEL_MAC;
    end

    // unmapped and reserved words read as zero
    always @* begin
        case (rd_sel)
            SEL_ID:   rdata_next = {CHIP_ID, CHIP_REV};
            SEL_STAT: rdata_next = stat_rv;
            SEL_CTRL: rdata_next = ctrl_rv;
            SEL_MAC:  rdata_next = mac_rv;
            default:  rdata_next = 32'h00000000;
        endcase
    end

    // ----------------------------------------
    // read answer
    // ----------------------------------------
    // rvalid follows every read, even one that lands on no register
    always @(posedge clk) begin
        if (!rst_n) begin
            reg_rdata_reg  <= 32'h00000000;
            reg_rvalid_reg <= 1'b0;
        end else begin
            reg_rvalid_reg <= reg_rd;
            if (reg_rd)
                reg_rdata_reg <= rdata_next;
        end
    end

    // ----------------------------------------
    // region flags
    // ----------------------------------------
    // flags keep the region of the last access until the next one
    always @(posedge clk) begin
        if (!rst_n) begin
            sys_hit_reg <= 1'b0;
            mac_hit_reg <= 1'b0;
        end else if (reg_rd || reg_wr) begin
            sys_hit_reg <= (acc_region == RGN_SYS);
            mac_hit_reg <= (acc_region == RGN_MAC);
        end
    end

endmodule

// ==== inc/rab_map.vh ====
// constants for the register access attribute bank
// assumes: included by bare name from the design files under logic/
`ifndef RAB_MAP_VH
`define RAB_MAP_VH

// ----------------------------------------
// address regions
// ----------------------------------------
`define RAB_SYS_LO      9'h000
`define RAB_SYS_HI      9'h0FF
`define RAB_MAC_LO      9'h100
`define RAB_MAC_HI      9'h1FC

// ----------------------------------------
// register offsets
// ----------------------------------------
`define RAB_ID_OFS      9'h000
`define RAB_STAT_OFS    9'h008
`define RAB_CTRL_OFS    9'h00C
`define RAB_MAC_OFS     9'h100

// ----------------------------------------
// id fields and reset values
// ----------------------------------------
`define RAB_ID_CHIP_LSB 16
`define RAB_STAT_RST    32'h00000080
`define RAB_CTRL_RST    32'h00000000
`define RAB_MAC_RST     32'h00000000
`define RAB_CTRL_KEEP   32'hFFFF0000
`define RAB_STAT_KEEP   32'h00000000
`define RAB_MAC_KEEP    32'h00000000

// ----------------------------------------
// per-bit attribute codes
// ----------------------------------------
`define RAB_AT_RW       4'h0
`define RAB_AT_RO       4'h1
`define RAB_AT_RS       4'h2
`define RAB_AT_WO       4'h3
`define RAB_AT_WC       4'h4
`define RAB_AT_WAC      4'h5
`define RAB_AT_RC       4'h6
`define RAB_AT_LH       4'h7
`define RAB_AT_LL       4'h8
`define RAB_AT_SC       4'h9
`define RAB_AT_STKH     4'hA

// ----------------------------------------
// attribute maps, one nibble per bit, bit 0 lowest
// ----------------------------------------
`define RAB_STAT_ATTR   128'h1111111111111111111110A987654321
`define RAB_CTRL_ATTR   128'h00000000000000000000000000000000
`define RAB_MAC_ATTR    128'h11111111111111110000000000000000

`endif

// ==== logic/rab_attr_bit.v ====
// one storage bit with a configurable access attribute
// assumes: rd and wr are one-cycle strobes on clk, src comes from logic on clk
`timescale 1ns/1ps
`include "rab_map.vh"

module rab_attr_bit #(
    parameter [3:0] ATTR    = 4'h0,
    parameter       KEEP    = 0,
    parameter       RST_VAL = 0
) (
    // clock and resets
    input  wire clk,
    input  wire rst_n,
    input  wire soft_rst,
    // access strobes for the owning register
    input  wire rd,
    input  wire wr,
    input  wire wdat,
    // hardware side
    input  wire src,
    output reg  q_reg,
    output wire rd_val
);

    reg q_next;
    reg fol_reg;    // sticky bit read, now follows its cause
    reg fol_next;

    // ----------------------------------------
    // next state per attribute
    // ----------------------------------------
    // hardware sets are written last so they win over clears
    always @* begin
        q_next   = q_reg;
        fol_next = fol_reg;
        case (ATTR)
            `RAB_AT_RW: begin
                if (wr) q_next = wdat;
            end
            `RAB_AT_RO: begin
                q_next = src;
            end
            `RAB_AT_RS: begin
                if (wr) q_next = wdat;
                if (rd) q_next = 1'b1;
            end
            `RAB_AT_WO: begin
                if (wr) q_next = wdat;
            end
            `RAB_AT_WC: begin
                if (wr && wdat) q_next = 1'b0;
                if (src) q_next = 1'b1;
            end
            `RAB_AT_WAC: begin
                if (wr) q_next = 1'b0;
                if (src) q_next = 1'b1;
            end
            `RAB_AT_RC, `RAB_AT_LH: begin
                if (rd) q_next = 1'b0;
                if (src) q_next = 1'b1;
            end
            `RAB_AT_LL: begin
                if (rd) q_next = 1'b1;
                if (!src) q_next = 1'b0;
            end
            `RAB_AT_SC: begin
                if (q_reg) q_next = 1'b0;
                if (wr && wdat) q_next = 1'b1;
            end
            `RAB_AT_STKH: begin
                if (fol_reg) begin
                    q_next   = src;
                    fol_next = src;
                end else if (src) begin
                    q_next = 1'b1;
                end
                if (rd && q_reg) begin
                    q_next   = src;
                    fol_next = src;
                end
            end
            default: begin
                q_next = q_reg;
            end
        endcase
    end

    // ----------------------------------------
    // storage with hardware and software reset
    // ----------------------------------------
    always @(posedge clk) begin
        if (!rst_n) begin
            q_reg   <= (RST_VAL != 0);
            fol_reg <= 1'b0;
        end else if (soft_rst && (KEEP == 0)) begin
            q_reg   <= (RST_VAL != 0);
            fol_reg <= 1'b0;
        end else begin
            q_reg   <= q_next;
            fol_reg <= fol_next;
        end
    end

    // read value: live source, zero, or stored
    assign rd_val = (ATTR == `RAB_AT_RO) ? src :
                    (ATTR == `RAB_AT_WO) ? 1'b0 : q_reg;

endmodule

// ==== tb/rab_bank_chk.sv ====
// assertions watching the ports of the register attribute bank
// assumes: bound into rab_bank, one clock, synchronous active-low reset
`timescale 1ns/1ps
module rab_chk (
    // clock and resets
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        soft_rst,
    // register port
    input wire logic        reg_rd,
    input wire logic        reg_wr,
    input wire logic [8:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata_reg,
    input wire logic        reg_rvalid_reg,
    // stored values and region flags
    input wire logic [31:0] stat_src,
    input wire logic [31:0] stat_q,
    input wire logic [31:0] ctrl_q,
    input wire logic        sys_hit_reg,
    input wire logic        mac_hit_reg
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // status register accesses outside soft reset
    sequence stat_rd;
        reg_rd && reg_addr == 9'h008 && !soft_rst;
    endsequence
    sequence stat_wr;
        reg_wr && reg_addr == 9'h008 && !soft_rst && !reg_rd;
    endsequence
    sequence sc_pulse;
        stat_q[8] ##1 !stat_q[8];
    endsequence
    rvalid_one_a: assert property (reg_rd |=> reg_rvalid_reg) else $error("no read answer");
    rvalid_idle_a: assert property (!reg_rd |=> !reg_rvalid_reg) else $error("stray read answer");
    ro_live_a: assert property (stat_rd |=> reg_rdata_reg[0] == $past(stat_src[0])) else $error("ro bit");
    rs_set_a: assert property (stat_rd and !reg_wr |=> stat_q[1]) else $error("read sets bit");
    wc_clear_a: assert property (stat_wr and reg_wdata[3] && !stat_src[3] |=> !stat_q[3]) else $error("wc bit");
    wac_clear_a: assert property (stat_wr and !stat_src[4] |=> !stat_q[4]) else $error("wac bit");
    rc_clear_a: assert property (stat_rd and !stat_src[5] |=> !stat_q[5] && reg_rdata_reg[5] == $past(stat_q[5]))
        else $error("rc bit");
    sc_pulse_a: assert property (stat_wr and reg_wdata[8] |=> sc_pulse) else $error("sc bit");
    soft_keep_a: assert property (soft_rst |=> ctrl_q == {$past(ctrl_q[31:16]), 16'h0000})
        else $error("soft reset keep");
    gap_zero_a: assert property (reg_rd && reg_addr == 9'h004 |=> reg_rdata_reg == 32'h00000000)
        else $error("gap read");
    sys_hit_a: assert property ((reg_rd || reg_wr) && !soft_rst && !reg_addr[8] && reg_addr[1:0] == 2'h0
        |=> sys_hit_reg && !mac_hit_reg) else $error("sys region");
    mac_hit_a: assert property ((reg_rd || reg_wr) && !soft_rst && reg_addr[8] && reg_addr[1:0] == 2'h0
        |=> mac_hit_reg && !sys_hit_reg) else $error("mac region");
endmodule

bind rab_bank rab_chk u_chk (.clk, .rst_n, .soft_rst, .reg_rd, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata_reg,
    .reg_rvalid_reg, .stat_src, .stat_q, .ctrl_q, .sys_hit_reg, .mac_hit_reg);

// ==== tb/tb_top.sv ====
// self-checking bench for the register attribute bank
// assumes: rab_bank with two arbitrary id parameters, 50 MHz clock
`timescale 1ns/1ps
module tb_top;
    localparam [15:0] ID_V  = 16'h0C3C; // arbitrary value
    localparam [15:0] REV_V = 16'h0002; // arbitrary value
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        soft_rst = 1'b0;
    logic        reg_rd = 1'b0;
    logic        reg_wr = 1'b0;
    logic [8:0]  reg_addr = 9'h000;
    logic [31:0] reg_wdata = 32'h0;
    logic [31:0] stat_src = 32'h0;
    logic [31:0] mac_src = 32'h0;
    logic [31:0] reg_rdata_reg, stat_q, ctrl_q, mac_q, d;
    logic        reg_rvalid_reg, sys_hit_reg, mac_hit_reg;
    int          err_total = 0;
    int          check_count = 0;

    rab_bank #(.CHIP_ID(ID_V), .CHIP_REV(REV_V)) dut (.clk(clk), .rst_n(rst_n), .soft_rst(soft_rst),
        .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata_reg(reg_rdata_reg), .reg_rvalid_reg(reg_rvalid_reg), .stat_src(stat_src), .stat_q(stat_q),
        .ctrl_src(32'h0), .ctrl_q(ctrl_q), .mac_src(mac_src), .mac_q(mac_q),
        .sys_hit_reg(sys_hit_reg), .mac_hit_reg(mac_hit_reg));

    // clock and hang guard
    always #10 clk = ~clk;
    initial begin
        #400000;
        err_total = err_total + 1;
        conclude;
    end

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count = check_count + 1;
        if (seen !== exp) begin
            err_total = err_total + 1;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task conclude;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task wr(input logic [8:0] a, input logic [31:0] v);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    // answer comes exactly one edge after the read edge
    task rd(input logic [8:0] a, output logic [31:0] v);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk("rvalid", {31'h0, reg_rvalid_reg}, 32'h1);
        v = reg_rdata_reg;
    endtask
    task src_pulse(input logic [31:0] m);
        @(posedge clk);
        stat_src <= m;
        @(posedge clk);
        stat_src <= 32'h0;
        #1;
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task t_id;
        rd(9'h000, d);
        chk("id", d, {ID_V, REV_V});
        wr(9'h000, 32'h0);
        rd(9'h000, d);
        chk("id kept", d, {ID_V, REV_V});
        wr(9'h00C, 32'h12345678);
        wr(9'h010, 32'hFFFFFFFF);
        rd(9'h004, d);
        chk("gap", d, 32'h0);
        chk("ctrl", ctrl_q, 32'h12345678);
        rd(9'h010, d);
        chk("unmapped", d, 32'h0);
        $display("id and unmapped done");
    endtask
    task t_attr;
        src_pulse(32'h00000278);
        wr(9'h008, 32'h0);
        chk("after zero", stat_q & 32'h238, 32'h228);
        wr(9'h008, 32'h8);
        chk("wc one", stat_q & 32'h8, 32'h0);
        @(posedge clk) stat_src <= 32'h81;
        rd(9'h008, d);
        chk("pre read", d & 32'h2E3, 32'h261);
        chk("post read", stat_q & 32'h2E2, 32'h82);
        @(posedge clk) stat_src <= 32'h200;
        rd(9'h008, d);
        chk("sticky held", stat_q & 32'h200, 32'h200);
        @(posedge clk) stat_src <= 32'h0;
        @(posedge clk) #1;
        chk("sticky drop", stat_q & 32'h200, 32'h0);
        wr(9'h008, 32'h104);
        chk("sc set", stat_q & 32'h100, 32'h100);
        chk("wo stored", stat_q & 32'h4, 32'h4);
        @(posedge clk) #1;
        chk("sc clear", stat_q & 32'h100, 32'h0);
        $display("attribute bits done");
    endtask
    task t_soft;
        wr(9'h00C, 32'hABCD1234);
        wr(9'h008, 32'h400);
        @(posedge clk) soft_rst <= 1'b1;
        @(posedge clk) soft_rst <= 1'b0;
        #1;
        chk("soft ctrl", ctrl_q, 32'hABCD0000);
        chk("soft stat", stat_q & 32'h400, 32'h0);
        @(posedge clk) rst_n <= 1'b0;
        @(posedge clk) rst_n <= 1'b1;
        #1;
        chk("hard ctrl", ctrl_q, 32'h0);
        chk("hard stat", stat_q & 32'h7FE, 32'h80);
        $display("resets done");
    endtask
    task t_region;
        @(posedge clk) mac_src <= 32'h5A5A0000;
        wr(9'h100, 32'hFFFFFFFF);
        chk("mac hit", {30'h0, mac_hit_reg, sys_hit_reg}, 32'h2);
        chk("mac q", mac_q, 32'h5A5AFFFF);
        rd(9'h100, d);
        chk("mac read", d, 32'h5A5AFFFF);
        rd(9'h1FC, d);
        chk("mac top", d, 32'h0);
        chk("top hit", {30'h0, mac_hit_reg, sys_hit_reg}, 32'h2);
        rd(9'h0FC, d);
        chk("sys hit", {30'h0, mac_hit_reg, sys_hit_reg}, 32'h1);
        $display("regions done");
    endtask

    // main sequence
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        t_id;
        t_attr;
        t_soft;
        t_region;
        conclude;
    end
endmodule
